/* logic/ivu_pkg.sv */
// Package for the interrupt vectoring unit: register map, field layout,
// reset values, fixed vector addresses, state and carrier types.
// Assumes a 32-bit APB slave port with byte addresses in the low 8 bits.
package ivu_pkg;
	localparam int IVU_NCH = 16;
	localparam int IVU_NEXT = 8;
	localparam int IVU_NPER = 4;

	localparam logic [7:0] IVU_CTRL_OFS = 8'h00;
	localparam logic [7:0] IVU_ISEG_OFS = 8'h04;
	localparam logic [7:0] IVU_CSEG_OFS = 8'h08;
	localparam logic [7:0] IVU_EDGE_OFS = 8'h0c;
	localparam logic [7:0] IVU_EPRL_OFS = 8'h10;
	localparam logic [7:0] IVU_PPRL_OFS = 8'h14;
	localparam logic [7:0] IVU_EVPR_OFS = 8'h18;
	localparam logic [7:0] IVU_PVPR_OFS = 8'h1c;
	localparam logic [7:0] IVU_PEND_OFS = 8'h20;
	localparam logic [7:0] IVU_STAT_OFS = 8'h24;
	localparam logic [7:0] IVU_MASK_OFS = 8'h28;
	localparam logic [7:0] IVU_STATE_OFS = 8'h2c;

	localparam int IVU_CPL_LSB = 0;
	localparam int IVU_IEN_BIT = 4;
	localparam int IVU_SEGMENT_SAVE_ENABLE_BIT = 5;
	localparam int IVU_TLSRC_BIT = 6;
	localparam int IVU_TLEN_BIT = 7;
	localparam logic [7:0] IVU_CTRL_RST = 8'h07;

	localparam int IVU_EV_ENTRY = 0;
	localparam int IVU_EV_TRAP = 1;
	localparam int IVU_EV_EXT = 2;
	localparam int IVU_EV_BOOT = 3;
	localparam int IVU_NEV = 4;

	localparam logic [23:0] IVU_BOOT_ADDR = 24'h000000;
	localparam logic [15:0] IVU_TRAP_OFS = 16'h0002;
	localparam logic [15:0] IVU_TOP_OFS = 16'h0004;

	typedef enum logic [9:0] {
		IVU_IDLE = 10'h001,
		IVU_BOOT = 10'h002,
		IVU_PCL = 10'h004,
		IVU_PCH = 10'h008,
		IVU_PCSR = 10'h010,
		IVU_PFLG = 10'h020,
		IVU_VHI = 10'h040,
		IVU_VLO = 10'h080,
		IVU_LOAD = 10'h100,
		IVU_BOOTLO = 10'h200
	} ivu_state_t;

	typedef enum logic [1:0] {
		IVU_K_NORM = 2'h0,
		IVU_K_TOP = 2'h1,
		IVU_K_TRAP = 2'h2,
		IVU_K_BOOT = 2'h3
	} ivu_kind_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [23:0] addr;
		logic [7:0] data;
	} ivu_mem_t;
endpackage

/* logic/ivu_core.sv */
// Interrupt vectoring unit: request intake, arbitration, entry sequence
// and vector table fetch, with an APB register slave.
// Assumes the CPU pulses arb_en_i at instruction boundaries, performs the
// stack pushes and byte reads asked on the mem port, and pulses iret_i.
`timescale 1ns/1ns
// What this block does
// - Accept peripheral, external pin and top-level requests
// - Eight external channels with selectable trigger edge
// - Top-level channel from pin or watchdog
// - Take peripheral and pin interrupts only when enabled and admitted
// - Acknowledged peripheral supplies vector from pointer register
// - Separate vector pointer register per peripheral
// - Table in first 256 bytes of interrupt segment
// - Boot address fetched from bytes 000000h, 000001h
// - Top-level vector at interrupt segment 0004h/0005h
// - External channels share one vector pointer register
// - Software sets upper vector bits, hardware lower
// - Table area not fenced off from code fetch
// - Divide trap vector at code segment 0002h/0003h
// - Divide trap entry pushes no flags
// - Entry: clear enable (top-level and normal only), push PCL, PCH, CODE_SEGMENT_REG, flags
// - Admit only priority strictly below current level
module ivu_core
	import ivu_pkg::*;
(
	input wire logic clk_i, // Core clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic ce_i, // Clock enable, freezes all state
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [7:0] periph_req_i, // Peripheral channel requests, two per peripheral
	output logic [7:0] periph_ack_o, // Acknowledge pulse per peripheral channel
	input wire logic [7:0] ext_pin_i, // External interrupt pins
	input wire logic nmi_pin_i, // Top-level pin
	input wire logic wdg_irq_i, // Timer/watchdog top-level pulse
	input wire logic divzero_i, // Divide-by-zero trap pulse from CPU
	input wire logic arb_en_i, // Instruction boundary, arbitration allowed
	input wire logic iret_i, // Interrupt return executed
	input wire logic [7:0] iret_csr_i, // Popped code segment with iret
	input wire logic [15:0] pc_i, // Current program counter
	input wire logic [7:0] flags_i, // Current flag register
	output ivu_mem_t mem_o, // Stack push or byte read request
	input wire logic mem_ack_i, // Memory request done
	input wire logic [7:0] mem_rdata_i, // Read byte
	output logic pc_load_o, // Load program counter pulse
	output logic [15:0] pc_o, // New program counter
	output logic [7:0] code_seg_o, // Segment used for code fetch
	output logic irq_o // Unmasked status interrupt
);
	ivu_state_t state_r, state_nxt;
	ivu_kind_t kind_r;
	ivu_mem_t mem_r, mem_nxt;
	logic [7:0] ctrl_r, iseg_r, cseg_r, edge_r, evpr_r, pend_r;
	logic [23:0] eprl_r;
	logic [11:0] pprl_r;
	logic [7:0] pvpr_r [IVU_NPER];
	logic [IVU_NEV-1:0] stat_r, mask_r, ev_set;
	logic [7:0] ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r, ext_edge;
	logic [2:0] nmi_sync_r;
	logic nmi_lvl_r, tl_pend_r, tl_active_r, trap_pend_r, use_isr_r;
	logic [23:0] vaddr_r;
	logic [15:0] pc_save_r;
	logic [7:0] vec_hi_r, seg_out_r, ack_r;
	logic [IVU_NCH-1:0] req_vec;
	logic [2:0] lvl [IVU_NCH];
	logic found;
	logic [3:0] best_idx;
	logic [2:0] best_lvl;
	logic take_top, take_norm, take_trap, idle;
	logic wr_en, setup;
	logic [7:0] norm_vec;

	// Shared decode for the register map
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= IVU_STATE_OFS;
	endfunction

	assign setup = psel && !penable;
	assign pready = psel && penable && ce_i;
	assign wr_en = pready && pwrite && mapped(paddr);

	// Pin inputs: three flops, a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < IVU_NEXT; g++) begin : g_ext
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					ext_s1_r[g] <= 1'b0;
					ext_s2_r[g] <= 1'b0;
					ext_s3_r[g] <= 1'b0;
					ext_lvl_r[g] <= 1'b0;
				end else if (ce_i) begin
					ext_s1_r[g] <= ext_pin_i[g];
					ext_s2_r[g] <= ext_s1_r[g];
					ext_s3_r[g] <= ext_s2_r[g];
					if (ext_s2_r[g] == ext_s3_r[g])
						ext_lvl_r[g] <= ext_s3_r[g];
				end
			end
			// Edge select bit high picks rising, low falling
			assign ext_edge[g] = (ext_s2_r[g] == ext_s3_r[g]) && (ext_s3_r[g] != ext_lvl_r[g])
				&& (ext_s3_r[g] == edge_r[g]);
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nmi_sync_r <= 3'h0;
			nmi_lvl_r <= 1'b0;
		end else if (ce_i) begin
			nmi_sync_r <= {nmi_sync_r[1:0], nmi_pin_i};
			if (nmi_sync_r[1] == nmi_sync_r[2])
				nmi_lvl_r <= nmi_sync_r[2];
		end
	end

	// Pending edges; a new edge beats an acknowledge or software clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_r <= 8'h00;
		end else if (ce_i) begin
			pend_r <= (pend_r & ~(take_norm && best_idx[3] ? 8'h01 << best_idx[2:0] : 8'h00)
				& ~(wr_en && hit(paddr, IVU_PEND_OFS) ? pwdata[7:0] : 8'h00)) | ext_edge;
		end
	end

	// Top-level source chosen by software: filtered pin rising edge or watchdog
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tl_pend_r <= 1'b0;
			trap_pend_r <= 1'b0;
		end else if (ce_i) begin
			if (ctrl_r[IVU_TLSRC_BIT] ? wdg_irq_i
				: (nmi_sync_r[1] == nmi_sync_r[2] && nmi_sync_r[2] && !nmi_lvl_r))
				tl_pend_r <= 1'b1;
			else if (take_top)
				tl_pend_r <= 1'b0;
			if (divzero_i)
				trap_pend_r <= 1'b1;
			else if (take_trap)
				trap_pend_r <= 1'b0;
		end
	end

	// Channels 0-7 peripherals (daisy order), 8-15 external pins
	always_comb begin
		for (int i = 0; i < IVU_NCH; i++) begin
			if (i < IVU_NEXT) begin
				req_vec[i] = periph_req_i[i];
				lvl[i] = pprl_r[3*(i/2) +: 3];
			end else begin
				req_vec[i] = pend_r[i-IVU_NEXT];
				lvl[i] = eprl_r[3*(i-IVU_NEXT) +: 3];
			end
		end
	end

	// Lowest level wins; strict compare keeps the lower index on a tie
	always_comb begin
		found = 1'b0;
		best_idx = 4'h0;
		best_lvl = 3'h7;
		for (int i = 0; i < IVU_NCH; i++) begin
			if (req_vec[i] && (!found || lvl[i] < best_lvl)) begin
				found = 1'b1;
				best_idx = 4'(i);
				best_lvl = lvl[i];
			end
		end
	end

	assign idle = state_r == IVU_IDLE;
	// Trap is synchronous to the instruction, so it goes first
	assign take_trap = idle && trap_pend_r;
	// Top level ignores the global enable; only a trap can nest into it
	assign take_top = idle && arb_en_i && !trap_pend_r && !tl_active_r && tl_pend_r
		&& ctrl_r[IVU_TLEN_BIT];
	assign take_norm = idle && arb_en_i && !trap_pend_r && !tl_active_r && !take_top
		&& ctrl_r[IVU_IEN_BIT] && found
		&& best_lvl < ctrl_r[IVU_CPL_LSB +: 3];

	// Pointer register: software upper bits, channel number in the lower bits
	always_comb begin
		if (best_idx[3])
			norm_vec = {evpr_r[7:4], best_idx[2:0], 1'b0};
		else
			norm_vec = {pvpr_r[best_idx[2:1]][7:2], best_idx[0], 1'b0};
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			IVU_IDLE: begin
				if (take_trap || take_top || take_norm)
					state_nxt = IVU_PCL;
			end
			IVU_BOOT: if (mem_ack_i) state_nxt = IVU_BOOTLO;
			IVU_BOOTLO: if (mem_ack_i) state_nxt = IVU_LOAD;
			IVU_PCL: if (mem_ack_i) state_nxt = IVU_PCH;
			IVU_PCH: begin
				if (mem_ack_i)
					state_nxt = ctrl_r[IVU_SEGMENT_SAVE_ENABLE_BIT] ? IVU_PCSR
						: (kind_r == IVU_K_TRAP ? IVU_VHI : IVU_PFLG);
			end
			IVU_PCSR: if (mem_ack_i) state_nxt = kind_r == IVU_K_TRAP ? IVU_VHI : IVU_PFLG;
			IVU_PFLG: if (mem_ack_i) state_nxt = IVU_VHI;
			IVU_VHI: if (mem_ack_i) state_nxt = IVU_VLO;
			IVU_VLO: if (mem_ack_i) state_nxt = IVU_LOAD;
			IVU_LOAD: state_nxt = IVU_IDLE;
			default: state_nxt = IVU_IDLE;
		endcase
	end

	// Memory request for the state about to be entered; vaddr_r is set
	// the same edge as entering PCL, so VHI/VLO see it settled
	always_comb begin
		mem_nxt = '0;
		case (state_nxt)
			IVU_BOOT: mem_nxt = '{1'b1, 1'b0, IVU_BOOT_ADDR, 8'h00};
			IVU_BOOTLO: mem_nxt = '{1'b1, 1'b0, IVU_BOOT_ADDR | 24'h1, 8'h00};
			IVU_PCL: mem_nxt = '{1'b1, 1'b1, 24'h0, pc_i[7:0]};
			IVU_PCH: mem_nxt = '{1'b1, 1'b1, 24'h0, pc_save_r[15:8]};
			IVU_PCSR: mem_nxt = '{1'b1, 1'b1, 24'h0, cseg_r};
			IVU_PFLG: mem_nxt = '{1'b1, 1'b1, 24'h0, flags_i};
			IVU_VHI: mem_nxt = '{1'b1, 1'b0, vaddr_r, 8'h00};
			IVU_VLO: mem_nxt = '{1'b1, 1'b0, vaddr_r | 24'h1, 8'h00};
			default: mem_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= IVU_BOOT;
			mem_r <= '{1'b1, 1'b0, IVU_BOOT_ADDR, 8'h00};
		end else if (ce_i) begin
			state_r <= state_nxt;
			mem_r <= mem_nxt;
		end
	end

	// Capture of the taken source and the table address it selects
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			kind_r <= IVU_K_BOOT;
			vaddr_r <= 24'h0;
			pc_save_r <= 16'h0;
			ack_r <= 8'h00;
		end else if (ce_i) begin
			ack_r <= 8'h00;
			if (take_trap) begin
				kind_r <= IVU_K_TRAP;
				vaddr_r <= {cseg_r, IVU_TRAP_OFS};
			end else if (take_top) begin
				kind_r <= IVU_K_TOP;
				vaddr_r <= {iseg_r, IVU_TOP_OFS};
			end else if (take_norm) begin
				kind_r <= IVU_K_NORM;
				vaddr_r <= {iseg_r, 8'h00, norm_vec};
				if (!best_idx[3])
					ack_r <= 8'h01 << best_idx[2:0];
			end
			if (idle)
				pc_save_r <= pc_i;
		end
	end

	// Vector bytes become the new program counter, high byte first
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vec_hi_r <= 8'h00;
			pc_o <= 16'h0;
			pc_load_o <= 1'b0;
		end else if (ce_i) begin
			pc_load_o <= 1'b0;
			if ((state_r == IVU_VHI || state_r == IVU_BOOT) && mem_ack_i)
				vec_hi_r <= mem_rdata_i;
			if ((state_r == IVU_VLO || state_r == IVU_BOOTLO) && mem_ack_i)
				pc_o <= {vec_hi_r, mem_rdata_i};
			if (state_r == IVU_LOAD)
				pc_load_o <= 1'b1;
		end
	end

	// Control register; top-level and normal entry clear enable, trap entry leaves it, iret sets it again
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_r <= IVU_CTRL_RST;
			cseg_r <= 8'h00;
			use_isr_r <= 1'b0;
			tl_active_r <= 1'b0;
		end else if (ce_i) begin
			if (wr_en && hit(paddr, IVU_CTRL_OFS))
				ctrl_r <= pwdata[7:0];
			if (wr_en && hit(paddr, IVU_CSEG_OFS))
				cseg_r <= pwdata[7:0];
			if (take_top || take_norm)
				ctrl_r[IVU_IEN_BIT] <= 1'b0;
			else if (iret_i)
				ctrl_r[IVU_IEN_BIT] <= 1'b1;
			if (take_top)
				tl_active_r <= 1'b1;
			else if (iret_i)
				tl_active_r <= 1'b0;
			if (state_r == IVU_LOAD && kind_r != IVU_K_TRAP && kind_r != IVU_K_BOOT) begin
				if (ctrl_r[IVU_SEGMENT_SAVE_ENABLE_BIT])
					cseg_r <= iseg_r;
				else
					use_isr_r <= 1'b1;
			end else if (iret_i) begin
				use_isr_r <= 1'b0;
				if (ctrl_r[IVU_SEGMENT_SAVE_ENABLE_BIT])
					cseg_r <= iret_csr_i;
			end
		end
	end

	// Configuration registers; the table area stays ordinary memory
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			iseg_r <= 8'h00;
			edge_r <= 8'h00;
			eprl_r <= 24'h0;
			pprl_r <= 12'h0;
			evpr_r <= 8'h00;
			for (int i = 0; i < IVU_NPER; i++)
				pvpr_r[i] <= 8'h00;
		end else if (ce_i && wr_en) begin
			if (hit(paddr, IVU_ISEG_OFS))
				iseg_r <= pwdata[7:0];
			if (hit(paddr, IVU_EDGE_OFS))
				edge_r <= pwdata[7:0];
			if (hit(paddr, IVU_EPRL_OFS))
				eprl_r <= pwdata[23:0];
			if (hit(paddr, IVU_PPRL_OFS))
				pprl_r <= pwdata[11:0];
			if (hit(paddr, IVU_EVPR_OFS))
				evpr_r <= pwdata[7:0];
			if (hit(paddr, IVU_PVPR_OFS))
				for (int i = 0; i < IVU_NPER; i++)
					pvpr_r[i] <= pwdata[8*i +: 8];
		end
	end

	assign ev_set = {state_r == IVU_LOAD && kind_r == IVU_K_BOOT, |ext_edge, take_trap,
		take_top || take_norm};

	// Sticky status, write one to clear; a same-cycle event wins
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stat_r <= '0;
			mask_r <= '0;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			stat_r <= (stat_r & ~(wr_en && hit(paddr, IVU_STAT_OFS)
				? pwdata[IVU_NEV-1:0] : '0)) | ev_set;
			if (wr_en && hit(paddr, IVU_MASK_OFS))
				mask_r <= pwdata[IVU_NEV-1:0];
			irq_o <= |(stat_r & mask_r);
		end
	end

	// Read data and error latched in the setup phase; zero wait states
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			seg_out_r <= 8'h00;
		end else if (ce_i) begin
			seg_out_r <= use_isr_r ? iseg_r : cseg_r;
			if (setup) begin
				pslverr <= !mapped(paddr);
				case (paddr)
					IVU_CTRL_OFS: prdata <= {24'h0, ctrl_r};
					IVU_ISEG_OFS: prdata <= {24'h0, iseg_r};
					IVU_CSEG_OFS: prdata <= {24'h0, cseg_r};
					IVU_EDGE_OFS: prdata <= {24'h0, edge_r};
					IVU_EPRL_OFS: prdata <= {8'h0, eprl_r};
					IVU_PPRL_OFS: prdata <= {20'h0, pprl_r};
					IVU_EVPR_OFS: prdata <= {24'h0, evpr_r};
					IVU_PVPR_OFS: prdata <= {pvpr_r[3], pvpr_r[2], pvpr_r[1], pvpr_r[0]};
					IVU_PEND_OFS: prdata <= {24'h0, pend_r};
					IVU_STAT_OFS: prdata <= {28'h0, stat_r};
					IVU_MASK_OFS: prdata <= {28'h0, mask_r};
					IVU_STATE_OFS: prdata <= {12'h0, use_isr_r, tl_active_r, kind_r,
						state_r, 6'h0};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	assign mem_o = mem_r;
	assign periph_ack_o = ack_r;
	assign code_seg_o = seg_out_r;
endmodule

/* tb/ivu_core_checker.sv */
// Checker for the interrupt vectoring unit: entry pushes, vector fetch, acknowledge pulses.
// Assumes ce_i stays high while an entry sequence runs.
`timescale 1ns/1ns
module ivu_core_checker
	import ivu_pkg::*;
(
	input wire logic clk_i, // In
	input wire logic rst_b_i, // In
	input wire logic ce_i, // In
	input wire logic psel, // In
	input wire logic penable, // In
	input wire logic pwrite, // In
	input wire logic [7:0] paddr, // In
	input wire logic [31:0] pwdata, // In
	input wire logic [31:0] prdata, // In
	input wire logic pready, // In
	input wire logic pslverr, // In
	input wire logic [7:0] periph_req_i, // In
	input wire logic [7:0] periph_ack_o, // In
	input wire logic [7:0] ext_pin_i, // In
	input wire logic nmi_pin_i, // In
	input wire logic wdg_irq_i, // In
	input wire logic divzero_i, // In
	input wire logic arb_en_i, // In
	input wire logic iret_i, // In
	input wire logic [7:0] iret_csr_i, // In
	input wire logic [15:0] pc_i, // In
	input wire logic [7:0] flags_i, // In
	input wire ivu_mem_t mem_o, // In
	input wire logic mem_ack_i, // In
	input wire logic [7:0] mem_rdata_i, // In
	input wire logic pc_load_o, // In
	input wire logic [15:0] pc_o, // In
	input wire logic [7:0] code_seg_o, // In
	input wire logic irq_o // In
);
	logic rd_ack;
	assign rd_ack = mem_o.valid && !mem_o.write && mem_ack_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_hi_lo;
		rd_ack && !mem_o.addr[0] |=> !mem_o.write && mem_o.addr == $past(mem_o.addr) + 24'h1;
	endproperty
	a_hi_lo: assert property (p_hi_lo) else $error("low byte not next");
	// Boot low byte at 000001h excluded, though its load timing is the same as the entry one
	property p_lo_load;
		rd_ack && mem_o.addr[0] && mem_o.addr != 24'h000001
			|-> ##2 (pc_load_o && pc_o[7:0] == $past(mem_rdata_i, 2));
	endproperty
	a_lo_load: assert property (p_lo_load) else $error("load after low byte wrong");
	property p_table_page;
		mem_o.valid && !mem_o.write |-> mem_o.addr[15:8] == 8'h00;
	endproperty
	a_table_page: assert property (p_table_page) else $error("vector read off page");
	property p_stand;
		mem_o.valid && !mem_ack_i |=> mem_o == $past(mem_o);
	endproperty
	a_stand: assert property (p_stand) else $error("request changed before ack");
	property p_ack_push;
		|periph_ack_o |-> mem_o.write && mem_o.data == pc_i[7:0] && !$past(mem_o.valid);
	endproperty
	a_ack_push: assert property (p_ack_push) else $error("entry not from idle with low pc");
	property p_ack_req;
		|periph_ack_o |-> (periph_ack_o & $past(periph_req_i)) == periph_ack_o;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_ack_pulse;
		|periph_ack_o |=> periph_ack_o == 8'h00;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
	property p_pc_held;
		$fell(pc_load_o) |-> $stable(pc_o);
	endproperty
	a_pc_held: assert property (p_pc_held) else $error("pc not held after load");
endmodule
bind ivu_core ivu_core_checker i_ivu_core_checker (.clk_i, .rst_b_i, .ce_i, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .periph_req_i, .periph_ack_o,
	.ext_pin_i, .nmi_pin_i, .wdg_irq_i, .divzero_i, .arb_en_i, .iret_i, .iret_csr_i, .pc_i,
	.flags_i, .mem_o, .mem_ack_i, .mem_rdata_i, .pc_load_o, .pc_o, .code_seg_o, .irq_o);

/* tb/ivu_cpu_model.sv */
// CPU side model: serves stack pushes and byte reads, logs every finished request.
// Assumes the core clock enable stays high; slow_i acks every other cycle.
`timescale 1ns/1ns
module ivu_cpu_model
	import ivu_pkg::*;
(
	input wire logic clk_i, // Core clock
	input wire logic rst_b_i, // Reset, active low
	input wire logic slow_i, // Answer every other cycle
	input wire ivu_mem_t mem_i, // Request from the core
	output logic mem_ack_o, // Request done
	output logic [7:0] mem_rdata_o // Read byte
);
	ivu_mem_t log_q[$];
	logic tog_r;
	logic [7:0] rd;
	assign rd = mem_i.addr[7:0] ^ mem_i.addr[23:16] ^ 8'h3c;
	assign mem_ack_o = mem_i.valid && (!slow_i || tog_r);
	// Inverted outside acks so a stale sample never matches
	assign mem_rdata_o = mem_ack_o ? rd : ~rd;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tog_r <= 1'b0;
		end else begin
			tog_r <= ~tog_r;
		end
	end
	// Log kept apart so the bench may empty it between entries
	always @(posedge clk_i) begin
		if (rst_b_i && mem_ack_o)
			log_q.push_back(mem_i.write ? mem_i : ivu_mem_t'({mem_i[33:8], rd}));
	end
endmodule

/* tb/interrupt_vectoring_unit_bench.sv */
// Bench for the interrupt vectoring unit: boot, peripheral, pin, top and trap entries.
// Assumes the CPU model logs each request; register access over APB.
`timescale 1ns/1ns
module interrupt_vectoring_unit_bench import ivu_pkg::*;;
	logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, nmi_pin_i = 1'b0, wdg_irq_i = 1'b0, divzero_i = 1'b0;
	logic arb_en_i = 1'b1, iret_i = 1'b0, slow = 1'b0, e_r;
	logic [7:0] paddr = 8'h00, periph_req_i = 8'h00, ext_pin_i = 8'h00, iret_csr_i = 8'h00;
	logic [7:0] flags_i = 8'h00, periph_ack_o, mem_rdata_i, code_seg_o, iseg, cseg, ack_seen;
	logic [7:0] vpr, es, ev;
	logic [15:0] pc_i = 16'h0000, pc_o;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, mem_ack_i, pc_load_o, irq_o;
	ivu_mem_t mem_o;
	int errors = 0, checks = 0, cyc = 0, acks = 0, idx, enc, nn;
	ivu_core i_ivu_core (.clk_i, .rst_b_i, .ce_i, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .periph_req_i, .periph_ack_o, .ext_pin_i, .nmi_pin_i,
		.wdg_irq_i, .divzero_i, .arb_en_i, .iret_i, .iret_csr_i, .pc_i, .flags_i, .mem_o,
		.mem_ack_i, .mem_rdata_i, .pc_load_o, .pc_o, .code_seg_o, .irq_o);
	ivu_cpu_model i_ivu_cpu_model (.clk_i, .rst_b_i, .slow_i(slow), .mem_i(mem_o),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
	always #25 clk_i = ~clk_i;
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (|periph_ack_o) acks <= acks + 1;
		if (|periph_ack_o) ack_seen <= periph_ack_o;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	function automatic logic [7:0] bt(input logic [23:0] a);
		return a[7:0] ^ a[23:16] ^ 8'h3c;
	endfunction
	task automatic chk(input string nm, input logic [33:0] x, input logic [33:0] got);
		checks++;
		if (got !== x) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, x, got);
		end
	endtask
	// Held until pready is sampled high, released at that edge; no wait count assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		r = prdata;
		e_r = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("register", {2'b00, x}, {2'b00, r});
	endtask
	// md: pushes before the two vector reads (0 boot, 2 trap, 3 plain, 4 with segment)
	task automatic entry(input int md, input logic [23:0] va);
		ivu_mem_t e[$];
		int n;
		n = 0;
		if (md > 0) e.push_back({2'b11, 24'h0, pc_i[7:0]});
		if (md > 0) e.push_back({2'b11, 24'h0, pc_i[15:8]});
		if (md == 4) e.push_back({2'b11, 24'h0, cseg});
		if (md > 2) e.push_back({2'b11, 24'h0, flags_i});
		e.push_back({2'b10, va, bt(va)});
		e.push_back({2'b10, va + 24'h1, bt(va + 24'h1)});
		while (pc_load_o !== 1'b1 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		chk("load seen", 34'h1, {33'h0, pc_load_o});
		chk("entries", 34'(e.size()), 34'(i_ivu_cpu_model.log_q.size()));
		foreach (e[i]) chk("entry", e[i], i_ivu_cpu_model.log_q[i]);
		chk("pc", {18'h0, bt(va), bt(va + 24'h1)}, {18'h0, pc_o});
		i_ivu_cpu_model.log_q = {};
	endtask
	task automatic iret();
		iret_i <= 1'b1;
		@(posedge clk_i);
		iret_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("code segment", {26'h0, cseg}, {26'h0, code_seg_o});
	endtask
	initial begin
		void'($urandom(32'hfd08));
		iseg = 8'h40 | 8'($urandom % 64);
		cseg = 8'h11;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		entry(0, 24'h000000);
		rdc(IVU_CTRL_OFS, 32'h07);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped", 34'h1, {33'h0, e_r});
		apb(1'b1, IVU_ISEG_OFS, {24'h0, iseg});
		apb(1'b1, IVU_CSEG_OFS, {24'h0, cseg});
		iret_csr_i <= cseg;
		apb(1'b1, IVU_PVPR_OFS, 32'h0);
		apb(1'b1, IVU_PPRL_OFS, 32'h2);
		apb(1'b1, IVU_CTRL_OFS, 32'h12);
		periph_req_i <= 8'h01;
		repeat (20) @(posedge clk_i);
		chk("ack at equal level", 34'h0, 34'(acks));
		arb_en_i <= 1'b0;
		apb(1'b1, IVU_CTRL_OFS, 32'h13);
		repeat (10) @(posedge clk_i);
		chk("ack off boundary", 34'h0, 34'(acks));
		arb_en_i <= 1'b1;
		entry(3, {iseg, 16'h0000});
		periph_req_i <= 8'h00;
		rdc(IVU_CTRL_OFS, 32'h03);
		iret();
		apb(1'b1, IVU_PPRL_OFS, 32'h0);
		for (int k = 0; k < 8; k++) begin
			idx = $urandom % 8;
			enc = $urandom % 2;
			vpr = 8'($urandom) & 8'hfc;
			slow <= 1'($urandom);
			pc_i <= 16'($urandom);
			flags_i <= 8'($urandom);
			apb(1'b1, IVU_PVPR_OFS, 32'(vpr) << (8 * (idx / 2)));
			apb(1'b1, IVU_CTRL_OFS, {26'h0, 1'(enc), 5'h17});
			periph_req_i <= 8'h1 << idx;
			entry(enc ? 4 : 3, {iseg, 8'h00, vpr[7:2], 1'(idx % 2), 1'b0});
			chk("ack channel", 34'h1 << idx, {26'h0, ack_seen});
			@(posedge clk_i);
			chk("isr segment", {26'h0, iseg}, {26'h0, code_seg_o});
			periph_req_i <= 8'h00;
			iret();
		end
		apb(1'b1, IVU_CTRL_OFS, 32'h07);
		es = 8'($urandom);
		apb(1'b1, IVU_EDGE_OFS, {24'h0, es});
		ext_pin_i <= ~es;
		repeat (8) @(posedge clk_i);
		apb(1'b1, IVU_PEND_OFS, 32'hff);
		for (int n = 0; n < 8; n++) begin
			ext_pin_i[n] <= es[n];
			repeat (8) @(posedge clk_i);
			rdc(IVU_PEND_OFS, 32'h1 << n);
			apb(1'b1, IVU_PEND_OFS, 32'hff);
			ext_pin_i[n] <= ~es[n];
			repeat (8) @(posedge clk_i);
			rdc(IVU_PEND_OFS, 32'h0);
		end
		// Pin pulse while frozen must leave no pending edge
		ce_i <= 1'b0;
		ext_pin_i[0] <= es[0];
		repeat (8) @(posedge clk_i);
		ext_pin_i[0] <= ~es[0];
		repeat (8) @(posedge clk_i);
		ce_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rdc(IVU_PEND_OFS, 32'h0);
		nn = $urandom % 8;
		ev = 8'($urandom);
		apb(1'b1, IVU_EPRL_OFS, 32'h0);
		apb(1'b1, IVU_EVPR_OFS, {24'h0, ev});
		apb(1'b1, IVU_CTRL_OFS, 32'h17);
		ext_pin_i[nn] <= es[nn];
		entry(3, {iseg, 8'h00, ev[7:4], nn[2:0], 1'b0});
		apb(1'b1, IVU_PEND_OFS, 32'hff);
		ext_pin_i[nn] <= ~es[nn];
		iret();
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, IVU_CTRL_OFS, {24'h0, 1'b1, 1'(s), 6'h07});
			if (s == 0) nmi_pin_i <= 1'b1;
			else wdg_irq_i <= 1'b1;
			@(posedge clk_i);
			wdg_irq_i <= 1'b0;
			entry(3, {iseg, 16'h0004});
			nmi_pin_i <= 1'b0;
			iret();
		end
		divzero_i <= 1'b1;
		@(posedge clk_i);
		divzero_i <= 1'b0;
		entry(2, {cseg, 16'h0002});
		// Handler ends with a plain return, so no iret pulse follows
		rdc(IVU_STAT_OFS, 32'h0f);
		apb(1'b1, IVU_MASK_OFS, 32'h02);
		@(posedge clk_i);
		chk("irq on", 34'h1, {33'h0, irq_o});
		apb(1'b1, IVU_STAT_OFS, 32'h02);
		@(posedge clk_i);
		chk("irq off", 34'h0, {33'h0, irq_o});
		rdc(IVU_STAT_OFS, 32'h0d);
		rdc(IVU_STATE_OFS, {12'h0, 2'b00, IVU_K_TRAP, IVU_IDLE, 6'h0});
		print_verdict();
	end
endmodule
